// File: core/sps_pkg.sv
package sps_pkg;

	// sizes of the paged data space
	localparam int PAGE_W     = 3;                  // page number width
	localparam int DADDR_W    = 8;                  // cpu data address width
	localparam int PADDR_W    = PAGE_W + DADDR_W;   // physical sram address width
	localparam int NUM_PAGES  = 8;                  // pages of 256 bytes
	localparam int PAGE_BYTES = 256;                // bytes reached by one data address

	// flag register layout
	localparam logic [7:0] FLAG_RESET   = 8'h00;    // flags after reset and on interrupt entry
	localparam int         FLAG_MODE_HI = 7;        // upper page addressing bit
	localparam int         FLAG_MODE_LO = 6;        // lower page addressing bit

	// page register reset value
	localparam logic [PAGE_W-1:0] PAGE_RESET = 3'h0; // all pointers start on page 0

	// stack pointer reset and step
	localparam logic [DADDR_W-1:0] SP_RESET = 8'h00; // stack pointer after reset
	localparam logic [DADDR_W-1:0] SP_STEP  = 8'h01; // one byte per push or pop

	// apb register byte offsets
	localparam int          APB_AW      = 12;       // decoded address width
	localparam logic [11:0] OFS_CURPAGE = 12'h000;  // current page pointer
	localparam logic [11:0] OFS_STKPAGE = 12'h004;  // stack page pointer
	localparam logic [11:0] OFS_IDXPAGE = 12'h008;  // index page pointer
	localparam logic [11:0] OFS_MVRPAGE = 12'h00c;  // block move read page
	localparam logic [11:0] OFS_MVWPAGE = 12'h010;  // block move write page
	localparam logic [11:0] OFS_FLAGS   = 12'h014;  // cpu flag register
	localparam logic [11:0] OFS_STKPTR  = 12'h018;  // stack pointer

	// kinds of cpu memory access
	typedef enum logic [2:0] {
		ACC_NORMAL     = 3'h0,  // plain data access
		ACC_STACK      = 3'h1,  // push, pop, call, return
		ACC_INDEXED    = 3'h3,  // source or destination indexed
		ACC_PTR_READ   = 3'h2,  // pointer read of a move increment
		ACC_PTR_WRITE  = 3'h6,  // pointer write back of a move increment
		ACC_MOVE_READ  = 3'h7,  // data read of a move increment
		ACC_MOVE_WRITE = 3'h5   // data write of a move increment
	} sps_kind_type;

	// one access request from the cpu core
	typedef struct packed {
		logic                valid;   // request present this cycle
		sps_kind_type        kind;    // what sort of access
		logic [DADDR_W-1:0]  addr;    // 8-bit data address, unused for stack
	} sps_access_type;

	// physical sram access towards the memory
	typedef struct packed {
		logic                valid;   // address valid this cycle
		sps_kind_type        kind;    // kind of the access it came from
		logic [PADDR_W-1:0]  addr;    // page joined with data address
	} sps_phys_type;

	// the page pointer set
	typedef struct packed {
		logic [PAGE_W-1:0] cur;  // current page
		logic [PAGE_W-1:0] stk;  // stack page
		logic [PAGE_W-1:0] idx;  // index page
		logic [PAGE_W-1:0] mvr;  // block move read page
		logic [PAGE_W-1:0] mvw;  // block move write page
	} sps_pages_type;

endpackage : sps_pkg

// File: core/sps_page_mux.sv
`timescale 1ns/10ps
module sps_page_mux
	import sps_pkg::*;
(
	input  wire sps_kind_type        kind,   // kind of access
	input  wire logic [1:0]          mode,   // page addressing field of the flags
	input  wire sps_pages_type       pages,  // page pointer set
	output logic [PAGE_W-1:0]        page    // selected page
);

	// picks the page for one access from its kind and the addressing field
	always_comb begin
		page = PAGE_RESET;
		unique case (kind)
			ACC_NORMAL, ACC_PTR_READ, ACC_PTR_WRITE: begin
				// page 0 unless the upper mode bit is set
				page = mode[1] ? pages.cur : PAGE_RESET;
			end
			ACC_STACK: begin
				page = pages.stk;
			end
			ACC_INDEXED: begin
				unique case (mode)
					2'h0:       page = PAGE_RESET;
					2'h2:       page = pages.idx;
					2'h1, 2'h3: page = pages.stk;
				endcase
			end
			ACC_MOVE_READ: begin
				page = pages.mvr;
			end
			ACC_MOVE_WRITE: begin
				page = pages.mvw;
			end
			default: begin
				// unused kind code goes to page 0
				page = PAGE_RESET;
			end
		endcase
	end

endmodule : sps_page_mux

// File: core/sps_page_select.sv
`timescale 1ns/10ps
module sps_page_select
	import sps_pkg::*;
(
	input  wire logic                mclk,          // 200 MHz clock
	input  wire logic                rst_n,         // synchronous reset, active low
	input  wire logic                psel,          // apb select
	input  wire logic                penable,       // apb access phase
	input  wire logic                pwrite,        // apb write
	input  wire logic [APB_AW-1:0]   paddr,         // apb byte address
	input  wire logic [31:0]         pwdata,        // apb write data
	input  wire logic [3:0]          pstrb,         // apb byte strobes
	output logic [31:0]              prdata,        // apb read data
	output logic                     pready,        // apb ready
	output logic                     pslverr,       // apb error, unmapped address
	input  wire sps_access_type      cpuAccess,     // cpu memory access request
	input  wire logic                spInc,         // stack pointer increment (push)
	input  wire logic                spDec,         // stack pointer decrement (pop)
	input  wire logic                cpuFlagWe,     // cpu writes the flag register
	input  wire logic [7:0]          cpuFlagData,   // flag value from the cpu
	input  wire logic                intEntry,      // interrupt entry pulse
	input  wire logic                intReturn,     // interrupt return pulse
	input  wire logic [7:0]          retFlagData,   // flag byte popped on return
	output sps_phys_type             physAccess,    // physical sram access
	output logic [7:0]               pushFlagData,  // flag byte to push on entry
	output logic                     pushFlagValid, // push strobe, one cycle
	output logic [7:0]               flags,         // current flag register
	output logic [DADDR_W-1:0]       stackPtr       // current stack pointer
);

	// whole state of the block
	typedef struct packed {
		sps_pages_type        pages;     // page pointer set
		logic [7:0]           flags;     // flag register
		logic [DADDR_W-1:0]   sp;        // stack pointer
		sps_phys_type         phys;      // registered physical access
		logic [7:0]           pushData;  // flags captured at entry
		logic                 pushValid; // push strobe
		logic [31:0]          prdata;    // bus read data
		logic                 pready;    // bus ready
		logic                 pslverr;   // bus error
	} sps_state_type;

	sps_state_type      s_q;        // registered state
	sps_state_type      s_d;        // next state
	logic [PAGE_W-1:0]  selPage;    // page picked for the request
	logic [DADDR_W-1:0] accAddr;    // data address used for the request
	logic               busAccess;  // access phase under way
	logic               busWrite;   // write takes effect this edge
	logic               hit;        // address maps to a register
	logic [31:0]        rdValue;    // read value of the addressed register

	// page selection for the current request
	sps_page_mux u_mux (
		.kind  (cpuAccess.kind),
		.mode  (s_q.flags[FLAG_MODE_HI:FLAG_MODE_LO]),
		.pages (s_q.pages),
		.page  (selPage)
	);

	// stack accesses use the internal pointer, all others the cpu address
	assign accAddr   = (cpuAccess.kind == ACC_STACK) ? s_q.sp : cpuAccess.addr;
	assign busAccess = psel && penable;
	assign busWrite  = busAccess && pwrite && s_q.pready && pstrb[0];

	// register read decode
	always_comb begin
		hit     = 1'b1;
		rdValue = 32'h0000_0000;
		unique case (paddr)
			OFS_CURPAGE: rdValue = {29'h0000_0000, s_q.pages.cur};
			OFS_STKPAGE: rdValue = {29'h0000_0000, s_q.pages.stk};
			OFS_IDXPAGE: rdValue = {29'h0000_0000, s_q.pages.idx};
			OFS_MVRPAGE: rdValue = {29'h0000_0000, s_q.pages.mvr};
			OFS_MVWPAGE: rdValue = {29'h0000_0000, s_q.pages.mvw};
			OFS_FLAGS:   rdValue = {24'h00_0000, s_q.flags};
			OFS_STKPTR:  rdValue = {24'h00_0000, s_q.sp};
			default:     hit = 1'b0;
		endcase
	end

	// next state
	always_comb begin
		s_d = s_q;
		// bus answer one cycle into the access phase
		s_d.pready  = busAccess && !s_q.pready;
		s_d.pslverr = busAccess && !s_q.pready && !hit;
		s_d.prdata  = (busAccess && !s_q.pready && !pwrite) ? rdValue : 32'h0000_0000;
		// register writes, page pointers keep three low bits
		if (busWrite) begin
			unique case (paddr)
				OFS_CURPAGE: s_d.pages.cur = pwdata[PAGE_W-1:0];
				OFS_STKPAGE: s_d.pages.stk = pwdata[PAGE_W-1:0];
				OFS_IDXPAGE: s_d.pages.idx = pwdata[PAGE_W-1:0];
				OFS_MVRPAGE: s_d.pages.mvr = pwdata[PAGE_W-1:0];
				OFS_MVWPAGE: s_d.pages.mvw = pwdata[PAGE_W-1:0];
				OFS_FLAGS:   s_d.flags     = pwdata[7:0];
				OFS_STKPTR:  s_d.sp        = pwdata[DADDR_W-1:0];
				default: begin
					// unmapped write is dropped
				end
			endcase
		end
		// stack pointer steps wrap within the 8-bit page
		if (spInc && !spDec) begin
			s_d.sp = s_q.sp + SP_STEP;
		end else if (spDec && !spInc) begin
			s_d.sp = s_q.sp - SP_STEP;
		end
		// flag updates, interrupt events override cpu and bus
		s_d.pushValid = 1'b0;
		if (intEntry) begin
			s_d.pushData  = s_q.flags;
			s_d.pushValid = 1'b1;
			s_d.flags     = FLAG_RESET;
		end else if (intReturn) begin
			s_d.flags = retFlagData;
		end else if (cpuFlagWe) begin
			s_d.flags = cpuFlagData;
		end
		// physical address, page as upper bits
		s_d.phys.valid = cpuAccess.valid;
		s_d.phys.kind  = cpuAccess.kind;
		s_d.phys.addr  = {selPage, accAddr};
	end

	// state register with synchronous reset
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			s_q.pages     <= '0;
			s_q.flags     <= FLAG_RESET;
			s_q.sp        <= SP_RESET;
			s_q.phys      <= '0;
			s_q.pushData  <= 8'h00;
			s_q.pushValid <= 1'b0;
			s_q.prdata    <= 32'h0000_0000;
			s_q.pready    <= 1'b0;
			s_q.pslverr   <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state register
	assign prdata        = s_q.prdata;
	assign pready        = s_q.pready;
	assign pslverr       = s_q.pslverr;
	assign physAccess    = s_q.phys;
	assign pushFlagData  = s_q.pushData;
	assign pushFlagValid = s_q.pushValid;
	assign flags         = s_q.flags;
	assign stackPtr      = s_q.sp;

	// checks on reset and page selection
	a_reset_clears_all: assert property (@(posedge mclk)
		!rst_n |=> (s_q.pages == '0 && s_q.flags == FLAG_RESET))
		else $error("reset left a pointer or flag set");

	a_normal_page_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		(cpuAccess.valid && cpuAccess.kind == ACC_NORMAL && !s_q.flags[FLAG_MODE_HI])
		|=> physAccess.addr[PADDR_W-1:DADDR_W] == PAGE_RESET)
		else $error("normal access left page 0 with paging off");

	// normal accesses and pointer reads follow the current page when paging is on
	a_normal_cur_page: assert property (@(posedge mclk) disable iff (!rst_n)
		(cpuAccess.valid && cpuAccess.kind inside {ACC_NORMAL, ACC_PTR_READ}
		 && s_q.flags[FLAG_MODE_HI])
		|=> physAccess.addr[PADDR_W-1:DADDR_W] == $past(s_q.pages.cur))
		else $error("normal or pointer read not on current page");

	a_stack_page_sel: assert property (@(posedge mclk) disable iff (!rst_n)
		(cpuAccess.valid && cpuAccess.kind == ACC_STACK)
		|=> physAccess.addr == {$past(s_q.pages.stk), $past(s_q.sp)})
		else $error("stack access not on stack page at stack pointer");

	a_index_page_sel: assert property (@(posedge mclk) disable iff (!rst_n)
		(cpuAccess.valid && cpuAccess.kind == ACC_INDEXED
		 && s_q.flags[FLAG_MODE_HI:FLAG_MODE_LO] == 2'h2)
		|=> physAccess.addr[PADDR_W-1:DADDR_W] == $past(s_q.pages.idx))
		else $error("indexed access not on index page");

	a_move_write_page: assert property (@(posedge mclk) disable iff (!rst_n)
		(cpuAccess.valid && cpuAccess.kind == ACC_MOVE_WRITE)
		|=> physAccess.addr == {$past(s_q.pages.mvw), $past(cpuAccess.addr)})
		else $error("move write not on block move write page");

	// checks on flags, stack pointer and bus
	a_int_entry_push: assert property (@(posedge mclk) disable iff (!rst_n)
		intEntry |=> (pushFlagValid && pushFlagData == $past(s_q.flags)
		              && flags == FLAG_RESET) ##1 !pushFlagValid || $past(intEntry))
		else $error("interrupt entry did not push and clear flags");

	a_int_return_flags: assert property (@(posedge mclk) disable iff (!rst_n)
		(intReturn && !intEntry) |=> flags == $past(retFlagData))
		else $error("interrupt return did not restore flags");

	a_stack_wrap_up: assert property (@(posedge mclk) disable iff (!rst_n)
		(spInc && !spDec && s_q.sp == 8'hff && !busWrite)
		|=> (stackPtr == 8'h00 && $stable(s_q.pages.stk)))
		else $error("stack pointer did not wrap to 00 in its page");

	a_bus_answer_time: assert property (@(posedge mclk) disable iff (!rst_n)
		(psel && penable && !pready) |=> pready ##1 (!pready || $past(psel && penable && !pready)))
		else $error("bus answer not after one wait cycle");

	// checks on move, index, pointer and stack paths, flag writes and bus errors
	// each but the bus error check looks one cycle past the request, as the register adds a cycle

	// block move read page, whatever the addressing field holds
	// the low address byte must pass through untouched
	a_move_read_page: assert property (@(posedge mclk) disable iff (!rst_n)
		(cpuAccess.valid && cpuAccess.kind == ACC_MOVE_READ)
		|=> physAccess.addr == {$past(s_q.pages.mvr), $past(cpuAccess.addr)})
		else $error("move read not on block move read page");

	// pointer read back and write back live on the normal page
	// so a move never looks for its own pointer in the buffer page
	a_ptr_write_page: assert property (@(posedge mclk) disable iff (!rst_n)
		(cpuAccess.valid && cpuAccess.kind == ACC_PTR_WRITE)
		|=> physAccess.addr[PADDR_W-1:DADDR_W]
		    == ($past(s_q.flags[FLAG_MODE_HI]) ? $past(s_q.pages.cur) : PAGE_RESET))
		else $error("pointer write back not on normal page");

	// indexed access with the field clear stays on page 0
	// this is the mode an interrupt routine starts in
	a_index_page_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		(cpuAccess.valid && cpuAccess.kind == ACC_INDEXED
		 && s_q.flags[FLAG_MODE_HI:FLAG_MODE_LO] == 2'h0)
		|=> physAccess.addr[PADDR_W-1:DADDR_W] == PAGE_RESET)
		else $error("indexed access left page 0 with field clear");

	// indexed access with the low field bit set uses the stack page
	// both field codes with that bit set share the stack page
	a_index_stack_page: assert property (@(posedge mclk) disable iff (!rst_n)
		(cpuAccess.valid && cpuAccess.kind == ACC_INDEXED && s_q.flags[FLAG_MODE_LO])
		|=> physAccess.addr[PADDR_W-1:DADDR_W] == $past(s_q.pages.stk))
		else $error("indexed access not on stack page");

	// every request comes out one cycle later with its kind
	// and, unless it is a stack access, with its own low address
	a_phys_follows_req: assert property (@(posedge mclk) disable iff (!rst_n)
		(cpuAccess.valid && cpuAccess.kind != ACC_STACK)
		|=> (physAccess.valid && physAccess.kind == $past(cpuAccess.kind)
		     && physAccess.addr[DADDR_W-1:0] == $past(cpuAccess.addr)))
		else $error("physical access does not follow the request");

	// pop below zero wraps to the top of the same page
	// the stack page pointer must not move with it
	a_stack_wrap_down: assert property (@(posedge mclk) disable iff (!rst_n)
		(spDec && !spInc && s_q.sp == 8'h00 && !busWrite)
		|=> (stackPtr == 8'hff && $stable(s_q.pages.stk)))
		else $error("stack pointer did not wrap to ff in its page");

	// a cpu flag write lands when no interrupt event competes
	// interrupt events take priority over it
	a_cpu_flag_write: assert property (@(posedge mclk) disable iff (!rst_n)
		(cpuFlagWe && !intEntry && !intReturn) |=> flags == $past(cpuFlagData))
		else $error("cpu flag write was lost");

	// the stack pointer only moves on a step or a bus write
	a_sp_holds_still: assert property (@(posedge mclk) disable iff (!rst_n)
		(!spInc && !spDec && !busWrite) |=> $stable(stackPtr))
		else $error("stack pointer moved without a step");

	// an error is only given together with the ready pulse
	a_error_with_ready: assert property (@(posedge mclk) disable iff (!rst_n)
		pslverr |-> pready)
		else $error("bus error without ready");

	// covers for the main scenarios
	c_paged_normal: cover property (@(posedge mclk) disable iff (!rst_n)
		cpuAccess.valid && cpuAccess.kind == ACC_NORMAL && s_q.flags[FLAG_MODE_HI]
		&& s_q.pages.cur != PAGE_RESET);
	c_int_round_trip: cover property (@(posedge mclk) disable iff (!rst_n)
		intEntry ##[1:20] intReturn);
	c_move_sequence: cover property (@(posedge mclk) disable iff (!rst_n)
		(cpuAccess.valid && cpuAccess.kind == ACC_PTR_READ)
		##1 (cpuAccess.valid && cpuAccess.kind == ACC_PTR_WRITE)
		##1 (cpuAccess.valid && cpuAccess.kind == ACC_MOVE_READ));
	c_bus_error: cover property (@(posedge mclk) disable iff (!rst_n)
		pready && pslverr);
	c_index_stack_mode: cover property (@(posedge mclk) disable iff (!rst_n)
		cpuAccess.valid && cpuAccess.kind == ACC_INDEXED && s_q.flags[FLAG_MODE_LO]);

endmodule : sps_page_select

// File: verif/sps_cpu_model.sv
`timescale 1ns/10ps
module sps_cpu_model
	import sps_pkg::*;
(
	input  wire logic       mclk,          // cpu clock
	input  wire logic       pushFlagValid, // flag push strobe
	input  wire logic [7:0] pushFlagData,  // flag byte pushed
	output sps_access_type  cpuAccess,     // access request
	output logic            spInc,         // push step
	output logic            spDec,         // pop step
	output logic            cpuFlagWe,     // flag write
	output logic [7:0]      cpuFlagData,   // flag value
	output logic            intEntry,      // interrupt entry
	output logic            intReturn,     // interrupt return
	output logic [7:0]      retFlagData    // popped flag byte
);
	logic [7:0] savedFlag_q = 8'h5a; // one-deep stack slot for the flag byte
	// quiet start
	initial begin
		cpuAccess = '0;
		{spInc, spDec, cpuFlagWe, intEntry, intReturn} = '0;
		cpuFlagData = 8'h00;
		retFlagData = 8'ha5;
	end
	// keep the pushed flag byte as the stack would
	always @(posedge mclk) begin
		if (pushFlagValid) savedFlag_q <= pushFlagData;
	end
	// one request per edge, back to back allowed
	task automatic access(input sps_kind_type k, input logic [7:0] a);
		@(posedge mclk);
		cpuAccess <= '{valid: 1'b1, kind: k, addr: a};
	endtask : access
	// idle address turns over so a stale value cannot pass
	task automatic idle();
		@(posedge mclk);
		cpuAccess <= '{valid: 1'b0, kind: ACC_NORMAL, addr: ~cpuAccess.addr};
	endtask : idle
	// ctl: 0 push, 1 pop, 2 flag write, 3 entry, 4 return
	task automatic pulse(input int ctl, input logic [7:0] d);
		@(posedge mclk);
		spInc <= (ctl == 0);
		spDec <= (ctl == 1);
		cpuFlagWe <= (ctl == 2);
		intEntry <= (ctl == 3);
		intReturn <= (ctl == 4);
		cpuFlagData <= d;
		retFlagData <= savedFlag_q;
		@(posedge mclk);
		{spInc, spDec, cpuFlagWe, intEntry, intReturn} <= '0;
	endtask : pulse
endmodule : sps_cpu_model

// File: verif/sps_page_select_bench.sv
`timescale 1ns/10ps
module sps_page_select_bench
	import sps_pkg::*;
;
	logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0; // bench drives
	logic [11:0]    paddr = '0;        // apb address
	logic [31:0]    pwdata = '0;       // apb write data
	logic [3:0]     pstrb = 4'hf;      // apb strobes
	logic [31:0]    prdata;            // apb read data
	logic           pready, pslverr;   // apb answer
	sps_access_type cpuAccess;         // cpu request
	logic spInc, spDec, cpuFlagWe, intEntry, intReturn, pushFlagValid; // strobes
	logic [7:0]     cpuFlagData, retFlagData, pushFlagData, flags, stackPtr; // bytes
	sps_phys_type   physAccess;        // physical access
	logic [31:0]    expQ[$];           // expected results in order
	int errors = 0, num_checks = 0, seed = 77;  // counts and seed
	logic [7:0]     a;                 // random data address
	sps_kind_type   kinds[7] = '{ACC_NORMAL, ACC_STACK, ACC_INDEXED, ACC_PTR_READ,
		ACC_PTR_WRITE, ACC_MOVE_READ, ACC_MOVE_WRITE}; // every access kind
	logic [2:0]     pg[5] = '{3'h3, 3'h5, 3'h6, 3'h1, 3'h2}; // cur stk idx mvr mvw
	always #2.5 mclk = ~mclk;
	sps_page_select uut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cpuAccess(cpuAccess), .spInc(spInc),
		.spDec(spDec), .cpuFlagWe(cpuFlagWe), .cpuFlagData(cpuFlagData),
		.intEntry(intEntry), .intReturn(intReturn), .retFlagData(retFlagData),
		.physAccess(physAccess), .pushFlagData(pushFlagData),
		.pushFlagValid(pushFlagValid), .flags(flags), .stackPtr(stackPtr));
	sps_cpu_model cpu (.mclk(mclk), .pushFlagValid(pushFlagValid),
		.pushFlagData(pushFlagData), .cpuAccess(cpuAccess), .spInc(spInc), .spDec(spDec),
		.cpuFlagWe(cpuFlagWe), .cpuFlagData(cpuFlagData), .intEntry(intEntry),
		.intReturn(intReturn), .retFlagData(retFlagData));
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// verdict and end of run
	task automatic report_and_stop();
		if (expQ.size() != 0) errors++;
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	// oldest note against a result; missing note counts as a mismatch
	task automatic take(input logic [31:0] seen);
		if (expQ.size() == 0) chk(seen, ~seen);
		else chk(seen, expQ.pop_front());
	endtask : take
	// page the rules pick for each kind and mode
	function automatic logic [2:0] expPage(sps_kind_type k, logic [1:0] m);
		case (k)
			ACC_STACK:      return pg[1];
			ACC_INDEXED:    return (m == 2'b00) ? 3'h0 : (m == 2'b10) ? pg[2] : pg[1];
			ACC_MOVE_READ:  return pg[3];
			ACC_MOVE_WRITE: return pg[4];
			default:        return m[1] ? pg[0] : 3'h0;
		endcase
	endfunction : expPage
	// one apb transfer, answer waited for under a bound
	task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d,
		input logic err);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		// answer taken at the rising edge that sees pready high, released there
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			report_and_stop();
		end
		chk({31'h0, pslverr}, {31'h0, err});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// watcher: every result takes the oldest note
	always @(negedge mclk) begin
		if (physAccess.valid === 1'b1) take({18'h0, physAccess.kind, physAccess.addr});
		if (pready === 1'b1 && pwrite === 1'b0) take(prdata);
	end
	// main sequence
	initial begin
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		for (int o = 0; o <= 28; o += 4) begin
			expQ.push_back(32'h0);
			apb(1'b0, 12'(o), 32'h0, o == 28);
		end
		apb(1'b1, 12'h01c, 32'hffffffff, 1'b1);
		$display("test reset_values done");
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, 12'(4 * i), {29'h1fffffff, pg[i]}, 1'b0);
			expQ.push_back({29'h0, pg[i]});
			apb(1'b0, 12'(4 * i), 32'h0, 1'b0);
		end
		pstrb <= 4'he;
		apb(1'b1, OFS_CURPAGE, 32'h7, 1'b0);
		pstrb <= 4'hf;
		expQ.push_back(32'h3);
		apb(1'b0, OFS_CURPAGE, 32'h0, 1'b0);
		$display("test page_registers done");
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, OFS_FLAGS, {24'h0, 2'(m), 6'h0}, 1'b0);
			for (int i = 0; i < 7; i++) begin
				a = 8'($random(seed));
				expQ.push_back({18'h0, kinds[i], expPage(kinds[i], 2'(m)),
					(kinds[i] == ACC_STACK) ? 8'h00 : a});
				cpu.access(kinds[i], a);
			end
			cpu.idle();
		end
		$display("test page_modes done");
		apb(1'b1, OFS_STKPTR, 32'hff, 1'b0);
		cpu.pulse(0, 8'h00);
		@(negedge mclk);
		chk({24'h0, stackPtr}, 32'h0);
		expQ.push_back({18'h0, ACC_STACK, pg[1], 8'h00});
		cpu.access(ACC_STACK, 8'h77);
		cpu.idle();
		cpu.pulse(1, 8'h00);
		@(negedge mclk);
		chk({24'h0, stackPtr}, 32'hff);
		$display("test stack_wrap done");
		apb(1'b1, OFS_FLAGS, 32'hc0, 1'b0);
		cpu.pulse(3, 8'h00);
		@(negedge mclk);
		chk({pushFlagValid, pushFlagData, flags}, {1'b1, 8'hc0, 8'h00});
		expQ.push_back({18'h0, ACC_NORMAL, 3'h0, 8'h12});
		cpu.access(ACC_NORMAL, 8'h12);
		cpu.idle();
		expQ.push_back(32'h3);
		apb(1'b0, OFS_CURPAGE, 32'h0, 1'b0);
		apb(1'b1, OFS_CURPAGE, 32'h7, 1'b0);
		cpu.pulse(2, 8'h40);
		expQ.push_back({18'h0, ACC_INDEXED, pg[1], 8'h34});
		cpu.access(ACC_INDEXED, 8'h34);
		cpu.idle();
		apb(1'b1, OFS_CURPAGE, 32'h3, 1'b0);
		cpu.pulse(4, 8'h00);
		@(negedge mclk);
		chk({24'h0, flags}, 32'hc0);
		expQ.push_back({18'h0, ACC_NORMAL, pg[0], 8'h56});
		cpu.access(ACC_NORMAL, 8'h56);
		cpu.idle();
		repeat (3) @(posedge mclk);
		$display("test interrupt_cycle done");
		// reset in mid run must clear the current page pointer and the flags set above
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		expQ.push_back(32'h0);
		apb(1'b0, OFS_CURPAGE, 32'h0, 1'b0);
		expQ.push_back(32'h0);
		apb(1'b0, OFS_FLAGS, 32'h0, 1'b0);
		$display("test mid_reset done");
		report_and_stop();
	end
endmodule : sps_page_select_bench
